//--- verilog/tac_pkg.sv
// Package for the temperature converter control block.
// Holds the register map, field layout, encodings and conversion timing.
// Assumes a 125 MHz system clock; timings are scaled to that rate.
package tac_pkg;

  // Register index of the single 16-bit control register; APB byte address is four times it.
  localparam logic [7:0] TEMP_CONVERTER_CONTROL_INDEX = 8'h06;
  localparam logic [7:0] TEMP_CONVERTER_CONTROL_ADDR  = {TEMP_CONVERTER_CONTROL_INDEX[5:0], 2'h0};
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // Control bits other than the reserved top two are writable.
  localparam logic [15:0] CTRL_WRITE_MASK = 16'h3FFF;

  localparam int BIT_DOUBLE_SPEED = 13;
  localparam int BIT_START = 12;
  localparam int BIT_BIAS = 11;
  localparam int BIT_CONTINUOUS = 10;
  localparam int BIT_ON_CHIP_TEMP = 9;
  localparam int BIT_INT_REF = 8;
  localparam int POS_REF_SEL = 6;
  localparam int POS_MUX = 4;
  localparam int POS_GAIN = 2;
  localparam int POS_RES = 0;

  localparam int CLK_MHZ = 125;

  // Conversion times in milliseconds, indexed by resolution code.
  localparam int TEMP_MS_0 = 3;
  localparam int TEMP_MS_1 = 6;
  localparam int TEMP_MS_2 = 12;
  localparam int TEMP_MS_3 = 24;
  localparam int EXT_MS_0 = 6;
  localparam int EXT_MS_1 = 24;
  localparam int EXT_MS_2 = 50;
  localparam int EXT_MS_3 = 100;
  localparam int IREF_MS_0 = 8;
  localparam int IREF_MS_1 = 32;
  localparam int IREF_MS_2 = 64;
  localparam int IREF_MS_3 = 128;

  // Magnitude bits of the result for each resolution code (sign not counted).
  localparam logic [3:0] TEMP_BITS_0 = 4'h9;
  localparam logic [3:0] EXT_BITS_0 = 4'hB;
  localparam logic [3:0] EXT_BITS_1 = 4'hD;
  localparam logic [3:0] EXT_BITS_2 = 4'hE;
  localparam logic [3:0] EXT_BITS_3 = 4'hF;

  // Reference source select codes.
  typedef enum logic [1:0] {
    TAC_REF_MAIN   = 2'h0,
    TAC_REF_EXCITE = 2'h1,
    TAC_REF_SUPPLY = 2'h2,
    TAC_REF_RSVD   = 2'h3
  } tac_ref_t;

  // Analog input routing: one-hot positive and negative selections.
  typedef struct packed {
    logic pos_temp_pin;
    logic pos_excite;
    logic pos_out_pin;
    logic pos_main_ref;
    logic neg_ground;
    logic neg_temp_pin;
  } tac_route_t;

  // Steering handed to the analog converter.
  typedef struct packed {
    logic       on_chip_temp;
    logic       internal_ref;
    tac_ref_t   ref_sel;
    logic       ref_reserved;
    tac_route_t route;
    logic [3:0] gain;
    logic [3:0] result_bits;
    logic       bias_on;
    logic       double_speed;
  } tac_analog_t;

  typedef enum logic [1:0] {
    TAC_IDLE  = 2'b00,
    TAC_SINGLE = 2'b01,
    TAC_CONT  = 2'b10
  } tac_state_t;

endpackage : tac_pkg

//--- verilog/tac_control.sv
// Temperature converter control register and conversion sequencer.
// Assumes an APB master on SYS_CLK and an analog converter that follows the
// steering outputs; conversion length is timed here from the settings.
// Restarts and the self-clearing start bit are sequenced here, not in the converter.
//
// Functional notes
// (R1) Double speed halves external conversion time.
// (R2) Writing start launches one conversion, self-clears.
// (R3) Bias bit switches temperature pin current.
// (R4) Continuous bit converts repeatedly without starts.
// (R5) Temperature bit picks on-chip sensor input.
// (R6) Host clears other fields before temperature mode.
// (R7) Internal reference bit overrides reference field.
// (R8) Reference field selects main, excitation, supply.
// (R9) Mux field routes converter input pairs.
// (R10) Gain field selects 1, 2, 4, 8.
// (R11) On-chip mode resolutions and 3-24 ms times.
// (R12) External reference resolutions, 6-100 ms times.
// (R13) Internal reference resolutions, 8-128 ms times.
// (R14) Host writes zero to reserved top bits.
// (R15) Start bit reads one while converting; continuous conversions leave it as written.
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
`default_nettype none

module tac_control #(
  parameter int MS_CYCLES = tac_pkg::CLK_MHZ * 1000
) (
  // Clock and reset
  input  wire logic                 SYS_CLK,
  input  wire logic                 RST_B,
  // APB slave
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [7:0]           PADDR,
  input  wire logic [31:0]          PWDATA,
  input  wire logic [3:0]           PSTRB,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  // Converter steering and status
  output tac_pkg::tac_analog_t      ANALOG,
  output logic                      CONV_ACTIVE,
  output logic                      CONV_DONE
);

  logic [15:0]          ctrl;
  tac_pkg::tac_state_t  state;
  tac_pkg::tac_state_t  next_state;
  logic [31:0]          cycle_left;
  logic                 access;
  logic                 hit;
  logic                 wr_ctrl;
  logic                 start_req;
  logic                 finish;
  logic [31:0]          conv_cycles;
  logic [15:0]          written;
  logic                 launch;
  logic                 hold_start;
  // Registered steering, one group of flops for each concern.
  logic                 on_chip_q;
  logic                 int_ref_q;
  tac_pkg::tac_ref_t    ref_sel_q;
  logic                 ref_rsvd_q;
  tac_pkg::tac_route_t  route_q;
  logic [3:0]           gain_q;
  logic [3:0]           bits_q;
  logic                 bias_q;
  logic                 double_q;

  // Conversion length in cycles for the current settings.
  function automatic logic [31:0] conv_time(input logic [15:0] c);
    int ms;
    ms = 0;
    if (c[tac_pkg::BIT_ON_CHIP_TEMP]) begin // (R11)
      case (c[tac_pkg::POS_RES +: 2])
        2'h0:    ms = tac_pkg::TEMP_MS_0;
        2'h1:    ms = tac_pkg::TEMP_MS_1;
        2'h2:    ms = tac_pkg::TEMP_MS_2;
        default: ms = tac_pkg::TEMP_MS_3;
      endcase
    end else if (c[tac_pkg::BIT_INT_REF]) begin // (R13)
      case (c[tac_pkg::POS_RES +: 2])
        2'h0:    ms = tac_pkg::IREF_MS_0;
        2'h1:    ms = tac_pkg::IREF_MS_1;
        2'h2:    ms = tac_pkg::IREF_MS_2;
        default: ms = tac_pkg::IREF_MS_3;
      endcase
    end else begin // (R12)
      case (c[tac_pkg::POS_RES +: 2])
        2'h0:    ms = tac_pkg::EXT_MS_0;
        2'h1:    ms = tac_pkg::EXT_MS_1;
        2'h2:    ms = tac_pkg::EXT_MS_2;
        default: ms = tac_pkg::EXT_MS_3;
      endcase
    end
    // Double speed is not offered in on-chip mode, so it is ignored there.
    if (c[tac_pkg::BIT_DOUBLE_SPEED] && !c[tac_pkg::BIT_ON_CHIP_TEMP]) begin // (R1)
      ms = ms / 2;
    end
    conv_time = 32'(ms * MS_CYCLES);
  endfunction : conv_time

  // Input pair for a mux code: exactly one positive and one negative leg is on.
  function automatic tac_pkg::tac_route_t route_of(input logic [1:0] m);
    tac_pkg::tac_route_t r;
    r = '0;
    case (m)
      2'h0: begin
        r.pos_temp_pin = 1'b1;
        r.neg_ground   = 1'b1;
      end
      2'h1: begin
        r.pos_excite   = 1'b1;
        r.neg_temp_pin = 1'b1;
      end
      2'h2: begin
        r.pos_out_pin  = 1'b1;
        r.neg_ground   = 1'b1;
      end
      default: begin
        r.pos_main_ref = 1'b1;
        r.neg_temp_pin = 1'b1;
      end
    endcase
    route_of = r;
  endfunction : route_of

  // Magnitude bits delivered for a resolution code in the present mode.
  function automatic logic [3:0] result_bits_of(input logic [15:0] c);
    logic [3:0] b;
    b = tac_pkg::EXT_BITS_3;
    if (c[tac_pkg::BIT_ON_CHIP_TEMP]) begin // (R11)
      b = tac_pkg::TEMP_BITS_0 + 4'(c[tac_pkg::POS_RES +: 2]);
    end else begin // (R12) (R13)
      case (c[tac_pkg::POS_RES +: 2])
        2'h0:    b = tac_pkg::EXT_BITS_0;
        2'h1:    b = tac_pkg::EXT_BITS_1;
        2'h2:    b = tac_pkg::EXT_BITS_2;
        default: b = tac_pkg::EXT_BITS_3;
      endcase
    end
    result_bits_of = b;
  endfunction : result_bits_of

  assign access  = PSEL && PENABLE;
  assign hit     = (PADDR == tac_pkg::TEMP_CONVERTER_CONTROL_ADDR);
  assign wr_ctrl = access && PWRITE && hit && (PSTRB[1:0] != 2'h0);
  // Only the upper byte lane carries the start bit.
  assign start_req = wr_ctrl && PSTRB[1] && PWDATA[tac_pkg::BIT_START]; // (R2)
  // A start launches a single conversion only if continuous mode is off after the write.
  assign launch = start_req && !written[tac_pkg::BIT_CONTINUOUS]; // (R2) (R4)
  // Writing zero to start must not make a running single conversion look finished.
  assign hold_start = wr_ctrl && PSTRB[1] && !PWDATA[tac_pkg::BIT_START]
                      && state == tac_pkg::TAC_SINGLE && !finish; // (R15)
  assign finish = (state != tac_pkg::TAC_IDLE) && (cycle_left <= 32'h1);
  assign conv_cycles = conv_time(ctrl);

  // Control word as it stands once the present write has landed.
  always_comb begin
    written = ctrl;
    if (wr_ctrl && PSTRB[0]) begin
      written[7:0] = PWDATA[7:0];
    end
    if (wr_ctrl && PSTRB[1]) begin
      written[15:8] = PWDATA[15:8] & tac_pkg::CTRL_WRITE_MASK[15:8]; // (R14)
    end
  end

  // Zero-wait slave; unmapped addresses answer with an error and read zero.
  assign PREADY  = 1'b1;
  assign PSLVERR = access && !hit;

  // Read data is captured in the setup phase so it stands through the access phase.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE && hit) begin
      PRDATA <= {16'h0000, ctrl}; // (R15)
    end else if (PSEL && !PENABLE) begin
      PRDATA <= 32'h0000_0000;
    end
  end

  // Control register; reserved top bits always hold zero.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl <= tac_pkg::CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        if (PSTRB[0]) begin
          ctrl[7:0] <= PWDATA[7:0];
        end
        if (PSTRB[1]) begin
          ctrl[15:8] <= PWDATA[15:8] & tac_pkg::CTRL_WRITE_MASK[15:8]; // (R14)
        end
      end
      if (hold_start) begin
        ctrl[tac_pkg::BIT_START] <= 1'b1; // (R15)
      end
      // A new start wins over completion; otherwise completion clears it.
      if (!start_req && finish && state == tac_pkg::TAC_SINGLE) begin
        ctrl[tac_pkg::BIT_START] <= 1'b0; // (R2)
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      tac_pkg::TAC_IDLE: begin
        if (ctrl[tac_pkg::BIT_CONTINUOUS]) begin
          next_state = tac_pkg::TAC_CONT; // (R4)
        end else if (launch) begin
          next_state = tac_pkg::TAC_SINGLE; // (R2)
        end
      end
      tac_pkg::TAC_SINGLE: begin
        if (ctrl[tac_pkg::BIT_CONTINUOUS]) begin
          next_state = tac_pkg::TAC_CONT;
        end else if (finish && !launch) begin
          next_state = tac_pkg::TAC_IDLE;
        end
      end
      tac_pkg::TAC_CONT: begin
        if (launch) begin
          next_state = tac_pkg::TAC_SINGLE; // (R2)
        end else if (!ctrl[tac_pkg::BIT_CONTINUOUS] && finish) begin
          next_state = tac_pkg::TAC_IDLE; // (R4)
        end
      end
      default: next_state = tac_pkg::TAC_IDLE;
    endcase
  end

  // Sequencer state; continuous mode takes precedence over a stored start bit.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= tac_pkg::TAC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Conversion timer; a start that leaves continuous mode off restarts it.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cycle_left <= 32'h0000_0000;
    end else if (launch) begin
      cycle_left <= conv_time(written); // (R2)
    end else if (state == tac_pkg::TAC_IDLE && next_state == tac_pkg::TAC_CONT) begin
      cycle_left <= conv_cycles;
    end else if (finish && state == tac_pkg::TAC_CONT) begin
      cycle_left <= conv_cycles; // (R4)
    end else if (cycle_left != 32'h0000_0000) begin
      cycle_left <= cycle_left - 32'h1;
    end
  end

  // Status flops: done pulses for one cycle after each conversion ends.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      CONV_DONE <= 1'b0;
      CONV_ACTIVE <= 1'b0;
    end else begin
      CONV_DONE <= finish;
      CONV_ACTIVE <= (next_state != tac_pkg::TAC_IDLE);
    end
  end

  // Analog steering is registered so the converter never sees decode glitches.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      on_chip_q  <= 1'b0;
      int_ref_q  <= 1'b0;
      ref_sel_q  <= tac_pkg::TAC_REF_MAIN;
      ref_rsvd_q <= 1'b0;
    end else begin
      on_chip_q  <= ctrl[tac_pkg::BIT_ON_CHIP_TEMP]; // (R5)
      int_ref_q  <= ctrl[tac_pkg::BIT_INT_REF]; // (R7)
      ref_sel_q  <= tac_pkg::tac_ref_t'(ctrl[tac_pkg::POS_REF_SEL +: 2]); // (R8)
      ref_rsvd_q <= !ctrl[tac_pkg::BIT_INT_REF]
                    && ctrl[tac_pkg::POS_REF_SEL +: 2] == tac_pkg::TAC_REF_RSVD; // (R8)
    end
  end

  // Route steering is one-hot per leg, so the converter never sees two positive or two negative legs on.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      route_q <= '0;
    end else begin
      route_q <= route_of(ctrl[tac_pkg::POS_MUX +: 2]); // (R9)
    end
  end

  // Gain steering is one-hot so the front end needs no decoder of its own.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      gain_q <= 4'h0;
    end else begin
      gain_q <= 4'h1 << ctrl[tac_pkg::POS_GAIN +: 2]; // (R10)
    end
  end

  // Resolution steering depends on the mode as well as the code.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      bits_q <= 4'h0;
    end else begin
      bits_q <= result_bits_of(ctrl); // (R11) (R12) (R13)
    end
  end

  // Double speed is dropped in on-chip mode, where it is not offered.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      bias_q   <= 1'b0;
      double_q <= 1'b0;
    end else begin
      bias_q   <= ctrl[tac_pkg::BIT_BIAS]; // (R3)
      double_q <= ctrl[tac_pkg::BIT_DOUBLE_SPEED] && !ctrl[tac_pkg::BIT_ON_CHIP_TEMP]; // (R1)
    end
  end

  // One carrier for the converter; every member comes straight from a flop.
  assign ANALOG = '{
    on_chip_temp: on_chip_q,
    internal_ref: int_ref_q,
    ref_sel:      ref_sel_q,
    ref_reserved: ref_rsvd_q,
    route:        route_q,
    gain:         gain_q,
    result_bits:  bits_q,
    bias_on:      bias_q,
    double_speed: double_q
  };

endmodule : tac_control
`default_nettype wire

//--- dv/tac_control_chk.sv
// Checker for the temperature converter control block.
// Sees only the top ports; bound from the testbench top file.
`timescale 1ns/100ps
`default_nettype none
module tac_control_chk (
  // Clock and reset
  input wire logic                 SYS_CLK,
  input wire logic                 RST_B,
  // Register bus
  input wire logic                 PSEL,
  input wire logic                 PENABLE,
  input wire logic                 PWRITE,
  input wire logic [7:0]           PADDR,
  input wire logic [31:0]          PWDATA,
  input wire logic [3:0]           PSTRB,
  // Steering and status
  input wire tac_pkg::tac_analog_t ANALOG,
  input wire logic                 CONV_ACTIVE,
  input wire logic                 CONV_DONE
);
  wire logic wr = PSEL && PENABLE && PWRITE && (&PSTRB[1:0])
                  && PADDR == tac_pkg::TEMP_CONVERTER_CONTROL_ADDR;
  logic        w1, w2;
  logic [15:0] d1, d2;
  // Steering lags a write by two edges, so the written word is kept that long.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      {w1, w2, d1, d2} <= '0;
    end else begin
      {w1, w2, d1, d2} <= {wr, w1, PWDATA[15:0], d1};
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  a_gain_decode: assert property (w2 |-> ANALOG.gain == (4'h1 << d2[3:2]))
    else $error("gain steering wrong");
  a_route_decode: assert property (w2 |-> ANALOG.route == (d2[5:4] == 2'h0 ? 6'h22 :
    d2[5:4] == 2'h1 ? 6'h11 : d2[5:4] == 2'h2 ? 6'h0A : 6'h05)) else $error("route wrong");
  a_bias_follow: assert property (w2 |-> ANALOG.bias_on == d2[11])
    else $error("bias wrong");
  a_int_ref: assert property (w2 |-> ANALOG.internal_ref == d2[8])
    else $error("reference enable wrong");
  a_temp_mode: assert property (w2 |-> ANALOG.on_chip_temp == d2[9])
    else $error("temperature mode wrong");
  a_double_speed: assert property (w2 |-> ANALOG.double_speed == (d2[13] && !d2[9]))
    else $error("double speed wrong");
  a_ref_select: assert property (w2 |-> ANALOG.ref_sel == d2[7:6]
    && ANALOG.ref_reserved == (d2[7:6] == 2'h3 && !d2[8])) else $error("reference wrong");
  a_result_bits: assert property (w2 |-> ANALOG.result_bits == (d2[9] ? 4'h9 + d2[1:0] :
    (d2[1:0] == 2'h0 ? 4'hB : 4'hC + d2[1:0]))) else $error("resolution wrong");
  a_start_busy: assert property (w2 && d2[12] && !d2[10] |-> CONV_ACTIVE)
    else $error("start did not launch");
  a_done_pulse: assert property (CONV_DONE |=> !CONV_DONE)
    else $error("done not a pulse");
endmodule : tac_control_chk
`default_nettype wire

//--- dv/tac_control_tb.sv
// Self-checking testbench for the temperature converter control block.
// Drives APB directly; a monitor compares read data against queued notes.
`timescale 1ns/100ps
`default_nettype none
module tac_control_tb;
  localparam int         MS = 10;
  localparam logic [7:0] A  = tac_pkg::TEMP_CONVERTER_CONTROL_ADDR;
  logic                 SYS_CLK, RST_B, PSEL, PENABLE, PWRITE;
  logic [7:0]           PADDR;
  logic [31:0]          PWDATA, PRDATA;
  logic [3:0]           PSTRB;
  logic                 PREADY, PSLVERR, CONV_ACTIVE, CONV_DONE;
  tac_pkg::tac_analog_t ANALOG;
  int                   n_errors, checks, n_done, p;
  logic [32:0]          expq[$];
  logic [32:0]          e;
  logic [15:0]          v;
  logic [15:0]          cfg[10] = '{16'h1000, 16'h1001, 16'h1002, 16'h1003, 16'h1100,
                                    16'h1103, 16'h1200, 16'h1203, 16'h3000, 16'h3100};
  int                   ms[10]  = '{6, 24, 50, 100, 8, 128, 3, 24, 3, 4};
  tac_control #(.MS_CYCLES(MS)) uut (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .ANALOG(ANALOG),
    .CONV_ACTIVE(CONV_ACTIVE), .CONV_DONE(CONV_DONE));
  initial begin
    SYS_CLK = 1'b0;
    forever #4 SYS_CLK = ~SYS_CLK;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input logic [32:0] x);
    @(posedge SYS_CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= {16'h0000, d};
    PSTRB   <= w ? 4'hF : 4'h0;
    if (!w) expq.push_back(x);
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic flag(input logic ok);
    checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH %0t status", $time);
    end
  endtask : flag
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  // Read answers are compared in the access cycle, where they are valid.
  always @(posedge SYS_CLK) begin
    if (CONV_DONE === 1'b1) n_done++;
    if (PSEL && PENABLE && PREADY && !PWRITE) begin
      e = expq.pop_front();
      checks++;
      if ({PSLVERR, PRDATA} !== e) begin
        n_errors++;
        $display("MISMATCH %0t read %h expected %h", $time, {PSLVERR, PRDATA}, e);
      end
    end
  end
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    n_errors++;
    summarize();
  end
  initial begin
    {RST_B, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    PSTRB = 4'h0;
    void'($urandom(59));
    repeat (8) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    apb(1'b0, A, 16'h0000, 33'h0);
    apb(1'b0, 8'h0A, 16'h0000, 33'h1_0000_0000);
    apb(1'b1, 8'h04, 16'h0FFF, 33'h0);
    apb(1'b0, A, 16'h0000, 33'h0);
    for (int i = 0; i < 8; i++) begin
      v = 16'($urandom) & 16'h2BFF;
      if (v[9]) v = v & 16'h0A03;
      if (v[7:6] == 2'h3 && !v[8]) v[6] = 1'b0;
      apb(1'b1, A, v, 33'h0);
      apb(1'b0, A, 16'h0000, {17'h0, v});
    end
    // Reads just before and after each nominal end bracket the conversion time.
    for (int i = 0; i < 10; i++) begin
      p = n_done;
      apb(1'b1, A, cfg[i], 33'h0);
      repeat (ms[i] * MS - 8) @(posedge SYS_CLK);
      apb(1'b0, A, 16'h0000, {17'h0, cfg[i]});
      repeat (12) @(posedge SYS_CLK);
      apb(1'b0, A, 16'h0000, {17'h0, cfg[i] & 16'hEFFF});
      flag(n_done == p + 1);
    end
    p = n_done;
    apb(1'b1, A, 16'h0400, 33'h0);
    repeat (200) @(posedge SYS_CLK);
    flag(CONV_ACTIVE === 1'b1 && n_done - p >= 3);
    apb(1'b1, A, 16'h0000, 33'h0);
    repeat (80) @(posedge SYS_CLK);
    p = n_done;
    repeat (80) @(posedge SYS_CLK);
    flag(n_done == p);
    apb(1'b1, A, 16'h1003, 33'h0);
    repeat (500) @(posedge SYS_CLK);
    apb(1'b1, A, 16'h1000, 33'h0);
    repeat (50) @(posedge SYS_CLK);
    apb(1'b0, A, 16'h0000, {17'h0, 16'h1000});
    repeat (20) @(posedge SYS_CLK);
    apb(1'b0, A, 16'h0000, 33'h0);
    summarize();
  end
endmodule : tac_control_tb
bind tac_control tac_control_chk chk (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
  .ANALOG(ANALOG), .CONV_ACTIVE(CONV_ACTIVE), .CONV_DONE(CONV_DONE));
`default_nettype wire
